// file: hw/ipm_pkg.sv
// Purpose: Shared constants, types and helpers for the interrupt priority block
// Assumes: AHB-Lite register access, one 32-bit word per register
// Notes:   Offsets are byte addresses within the low 256 bytes
package ipm_pkg;

  localparam int unsigned NUM_VEC  = 256;
  localparam int unsigned NUM_PMI  = 16;

  localparam logic [7:0] VEC_LEGACY   = 8'h00;
  localparam logic [7:0] VEC_RSV_ONE  = 8'h01;
  localparam logic [7:0] VEC_NMI      = 8'h02;
  localparam logic [7:0] VEC_RSV_LO   = 8'h03;
  localparam logic [7:0] VEC_RSV_HI   = 8'h0E;
  localparam logic [7:0] VEC_SPURIOUS = 8'h0F;
  localparam logic [7:0] VEC_GEN_LO   = 8'h10;
  localparam logic [3:0] PMI_FW_FIRST = 4'h4;

  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_TPR      = 8'h04;
  localparam logic [7:0] OFF_ACQUIRE  = 8'h08;
  localparam logic [7:0] OFF_DONE     = 8'h0C;
  localparam logic [7:0] OFF_STATUS   = 8'h10;
  localparam logic [7:0] OFF_FW_CLEAR = 8'h14;
  localparam logic [2:0] PEND_PAGE    = 3'h1;
  localparam logic [2:0] INSVC_PAGE   = 3'h2;

  localparam int unsigned CTRL_EXT_EN_BIT  = 0;
  localparam int unsigned CTRL_COLLECT_BIT = 1;
  localparam int unsigned CTRL_MC_BIT      = 2;
  localparam int unsigned CTRL_LEGACY_BIT  = 3;
  localparam int unsigned CTRL_LCTRL_BIT   = 4;
  localparam int unsigned CTRL_LFLAGS_BIT  = 5;
  localparam int unsigned MASK_CLASS_FIELD_LSB      = 4;
  localparam int unsigned MASK_ALL_MASKABLE_BIT_BIT      = 16;
  localparam int unsigned FWCLR_WARM_BIT   = 0;
  localparam int unsigned FWCLR_PMI_LSB    = 16;
  localparam int unsigned STAT_WARM_BIT    = 0;
  localparam int unsigned STAT_INSVC_BIT   = 1;
  localparam int unsigned STAT_DWARM_BIT   = 2;
  localparam int unsigned STAT_DPMI_BIT    = 3;
  localparam int unsigned STAT_DEXT_BIT    = 4;
  localparam int unsigned STAT_TOP_LSB     = 8;
  localparam int unsigned STAT_PMI_LSB     = 16;

  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef enum logic {IPM_MSG_EXT, IPM_MSG_PMI} ipm_msg_kind_e;

  typedef struct packed {
    logic          valid;
    ipm_msg_kind_e kind;
    logic [7:0]    vector;
  } ipm_msg_s;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
  } ipm_bus_req_s;

  // Larger rank wins: NMI over legacy cascade over 16..255 by number
  function automatic logic [8:0] ipm_rank(input logic [7:0] v);
    if (v == VEC_NMI)
      return 9'h101;
    else if (v == VEC_LEGACY)
      return 9'h100;
    else if (v >= VEC_GEN_LO)
      return {1'b0, v};
    else
      return 9'h000;
  endfunction

  function automatic logic ipm_reserved(input logic [7:0] v);
    return (v == VEC_RSV_ONE) || ((v >= VEC_RSV_LO) && (v <= VEC_SPURIOUS));
  endfunction

endpackage

// file: hw/ipm_vec_pick.sv
// Purpose: Pick the highest ranked vector from a 256-bit set
// Assumes: Reserved vectors are never set in the input
// Notes:   Pure combinational priority search
`timescale 1ns/1ps
module ipm_vec_pick
  import ipm_pkg::*;
(
  input  wire logic [NUM_VEC-1:0] bits,
  output logic                    found,
  output logic [7:0]              vec
);

  always_comb
  begin
    found = 1'b0;
    vec   = VEC_SPURIOUS;
    // Upward scan, so the last hit is the highest number
    for (int i = 16; i < NUM_VEC; i++)
    begin
      if (bits[i])
      begin
        found = 1'b1;
        vec   = 8'(i);
      end
    end
    if (bits[VEC_LEGACY])
    begin
      found = 1'b1;
      vec   = VEC_LEGACY;
    end
    if (bits[VEC_NMI])
    begin
      found = 1'b1;
      vec   = VEC_NMI;
    end
  end

endmodule // ipm_vec_pick

// file: hw/ipm_ahb_port.sv
// Purpose: AHB-Lite slave front end for the interrupt priority registers
// Assumes: Single word transfers, one slave on the bus
// Notes:   Reads take one wait state so read side effects and data are registered
`timescale 1ns/1ps
module ipm_ahb_port
  import ipm_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         arst_n,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic         hready,
  output ipm_bus_req_s      req,
  output logic              hreadyout,
  output logic              hresp
);

  typedef struct packed {
    logic       ph_valid;
    logic       ph_write;
    logic       ph_mapped;
    logic [7:0] ph_addr;
    logic       rd_done;
  } ipm_ahb_state_s;

  ipm_ahb_state_s state_reg;
  ipm_ahb_state_s state_next;
  logic           stall;

  always_comb
  begin
    state_next = state_reg;
    stall      = state_reg.ph_valid & ~state_reg.ph_write & ~state_reg.rd_done;
    // Unmapped reads land on a write-only slot, so they return zero and touch nothing
    req.rd     = stall;
    req.wr     = state_reg.ph_valid & state_reg.ph_write & state_reg.ph_mapped;
    req.addr   = state_reg.ph_mapped ? state_reg.ph_addr : OFF_FW_CLEAR;
    hreadyout  = ~stall;
    hresp      = 1'b0;
    if (stall)
      state_next.rd_done = 1'b1;
    else if (hready)
    begin
      state_next.ph_valid  = hsel & htrans[1];
      state_next.ph_write  = hwrite;
      state_next.ph_mapped = (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'b00);
      state_next.ph_addr   = haddr[7:0];
      state_next.rd_done   = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

endmodule // ipm_ahb_port

// file: hw/ipm_interrupt_priority.sv
// Purpose: Pending, ranking, enable, masking and in-service nesting of interrupts
// Assumes: Pins and bus messages are synchronous to mclk
// Notes:   Acquire by reading the acquire register, retire by writing service done
//
// Design decisions made here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
module ipm_interrupt_priority
  import ipm_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         arst_n,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic [31:0]       hrdata,
  input  ipm_msg_s          msg,
  input  wire logic         warm_restart_pin,
  input  wire logic         pmi_pin,
  output logic              divert_warm,
  output logic              divert_pmi,
  output logic [3:0]        divert_pmi_vector,
  output logic              divert_pmi_fw,
  output logic              divert_ext,
  output logic [7:0]        ext_vector
);

  typedef struct packed {
    logic               ext_irq_enable_bit;
    logic               collect_enable_bit;
    logic               machine_check_mask_bit;
    logic               legacy_mode;
    logic               legacy_ctrl_irq_bit;
    logic               legacy_flags_irq_bit;
    logic               mask_all_maskable_bit;
    logic [3:0]         mask_class_field;
    logic [NUM_VEC-1:0] pend;
    logic [NUM_VEC-1:0] insvc;
    logic               warm_pend;
    logic [NUM_PMI-1:0] pmi_pend;
    logic               warm_pin_q;
    logic               pmi_pin_q;
    logic [31:0]        rdata;
    logic               div_warm;
    logic               div_pmi;
    logic [3:0]         div_pmi_vec;
    logic               div_ext;
    logic [7:0]         div_vec;
  } ipm_state_s;

  ipm_state_s   state_reg;
  ipm_state_s   state_next;
  ipm_bus_req_s req;
  logic         p_found;
  logic [7:0]   p_vec;
  logic         i_found;
  logic [7:0]   i_vec;
  logic         ext_deliver;
  logic         outranks;
  logic         unmasked;
  logic [7:0]   acq_vec;
  logic         acq_hit;
  logic         done_hit;
  logic         warm_take;
  logic         pmi_take;

  ipm_ahb_port u_port (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hready    (hready),
    .req       (req),
    .hreadyout (hreadyout),
    .hresp     (hresp)
  );

  ipm_vec_pick u_pend_pick (
    .bits  (state_reg.pend),
    .found (p_found),
    .vec   (p_vec)
  );

  ipm_vec_pick u_insvc_pick (
    .bits  (state_reg.insvc),
    .found (i_found),
    .vec   (i_vec)
  );

  assign hrdata            = state_reg.rdata;
  assign divert_warm       = state_reg.div_warm;
  assign divert_pmi        = state_reg.div_pmi;
  assign divert_pmi_vector = state_reg.div_pmi_vec;
  assign divert_pmi_fw     = state_reg.div_pmi & (state_reg.div_pmi_vec >= PMI_FW_FIRST);
  assign divert_ext        = state_reg.div_ext;
  assign ext_vector        = state_reg.div_vec;

  always_comb
  begin
    state_next = state_reg;
    // Legacy mode also needs the control flag clear or the flags flag set
    ext_deliver = state_reg.ext_irq_enable_bit & (~state_reg.legacy_mode
                  | ~state_reg.legacy_ctrl_irq_bit | state_reg.legacy_flags_irq_bit);
    // Equal or lower than the top in-service vector stays masked
    outranks = ~i_found || (ipm_rank(p_vec) > ipm_rank(i_vec));
    unmasked = 1'b0;
    if (p_found)
    begin
      if (p_vec == VEC_NMI)
        unmasked = outranks;
      else if (p_vec == VEC_LEGACY)
        unmasked = ~state_reg.mask_all_maskable_bit & outranks;
      else
        unmasked = ~state_reg.mask_all_maskable_bit & outranks
                   & (p_vec[7:4] > state_reg.mask_class_field);
    end
    acq_vec  = unmasked ? p_vec : VEC_SPURIOUS;
    acq_hit  = req.rd && (req.addr == OFF_ACQUIRE);
    done_hit = req.wr && (req.addr == OFF_DONE);

    // Clears first, so that a same-cycle arrival below wins
    if (req.wr)
    begin
      case (req.addr)
        OFF_CTRL:
        begin
          state_next.ext_irq_enable_bit     = hwdata[CTRL_EXT_EN_BIT];
          state_next.collect_enable_bit     = hwdata[CTRL_COLLECT_BIT];
          state_next.machine_check_mask_bit = hwdata[CTRL_MC_BIT];
          state_next.legacy_mode            = hwdata[CTRL_LEGACY_BIT];
          state_next.legacy_ctrl_irq_bit    = hwdata[CTRL_LCTRL_BIT];
          state_next.legacy_flags_irq_bit   = hwdata[CTRL_LFLAGS_BIT];
        end
        OFF_TPR:
        begin
          state_next.mask_class_field      = hwdata[MASK_CLASS_FIELD_LSB +: 4];
          state_next.mask_all_maskable_bit = hwdata[MASK_ALL_MASKABLE_BIT_BIT];
        end
        OFF_DONE:
        begin
          if (i_found)
            state_next.insvc[i_vec] = 1'b0;
        end
        OFF_FW_CLEAR:
        begin
          if (hwdata[FWCLR_WARM_BIT])
            state_next.warm_pend = 1'b0;
          state_next.pmi_pend = state_reg.pmi_pend & ~hwdata[FWCLR_PMI_LSB +: NUM_PMI];
        end
        default:
        begin
          state_next.rdata = state_reg.rdata;
        end
      endcase
    end

    if (req.rd)
    begin
      state_next.rdata = WORD_ZERO;
      case (req.addr)
        OFF_CTRL:
        begin
          state_next.rdata[CTRL_EXT_EN_BIT]  = state_reg.ext_irq_enable_bit;
          state_next.rdata[CTRL_COLLECT_BIT] = state_reg.collect_enable_bit;
          state_next.rdata[CTRL_MC_BIT]      = state_reg.machine_check_mask_bit;
          state_next.rdata[CTRL_LEGACY_BIT]  = state_reg.legacy_mode;
          state_next.rdata[CTRL_LCTRL_BIT]   = state_reg.legacy_ctrl_irq_bit;
          state_next.rdata[CTRL_LFLAGS_BIT]  = state_reg.legacy_flags_irq_bit;
        end
        OFF_TPR:
        begin
          state_next.rdata[MASK_CLASS_FIELD_LSB +: 4] = state_reg.mask_class_field;
          state_next.rdata[MASK_ALL_MASKABLE_BIT_BIT]      = state_reg.mask_all_maskable_bit;
        end
        OFF_ACQUIRE:
        begin
          state_next.rdata[7:0] = acq_vec;
          // A spurious answer leaves every mark untouched
          if (unmasked)
          begin
            state_next.pend[p_vec]  = 1'b0;
            state_next.insvc[p_vec] = 1'b1;
          end
        end
        OFF_STATUS:
        begin
          state_next.rdata[STAT_WARM_BIT]          = state_reg.warm_pend;
          state_next.rdata[STAT_INSVC_BIT]         = i_found;
          state_next.rdata[STAT_DWARM_BIT]         = state_reg.div_warm;
          state_next.rdata[STAT_DPMI_BIT]          = state_reg.div_pmi;
          state_next.rdata[STAT_DEXT_BIT]          = state_reg.div_ext;
          state_next.rdata[STAT_TOP_LSB +: 8]      = i_vec;
          state_next.rdata[STAT_PMI_LSB +: NUM_PMI] = state_reg.pmi_pend;
        end
        default:
        begin
          if (req.addr[7:5] == PEND_PAGE)
            state_next.rdata = state_reg.pend[{req.addr[4:2], 5'h00} +: 32];
          else if (req.addr[7:5] == INSVC_PAGE)
            state_next.rdata = state_reg.insvc[{req.addr[4:2], 5'h00} +: 32];
        end
      endcase
    end

    // Arrivals keep pending even while something is in service
    state_next.warm_pin_q = warm_restart_pin;
    state_next.pmi_pin_q  = pmi_pin;
    if (warm_restart_pin && !state_reg.warm_pin_q)
      state_next.warm_pend = 1'b1;
    if (pmi_pin && !state_reg.pmi_pin_q)
      state_next.pmi_pend[0] = 1'b1;
    if (msg.valid)
    begin
      if (msg.kind == IPM_MSG_PMI)
      begin
        // Own vector space, kept apart from the external bits
        if (msg.vector < 8'(NUM_PMI))
          state_next.pmi_pend[msg.vector[3:0]] = 1'b1;
      end
      else if (!ipm_reserved(msg.vector))
        state_next.pend[msg.vector] = 1'b1;
    end

    // Diversion only while enabled; warm over management over external
    warm_take = state_reg.warm_pend & ~state_reg.machine_check_mask_bit;
    pmi_take  = (|state_reg.pmi_pend) & state_reg.collect_enable_bit;
    state_next.div_warm = warm_take;
    state_next.div_pmi  = pmi_take & ~warm_take;
    state_next.div_ext  = ext_deliver & unmasked & ~warm_take & ~pmi_take;
    state_next.div_vec  = acq_vec;
    state_next.div_pmi_vec = 4'h0;
    for (int k = NUM_PMI - 1; k >= 0; k--)
    begin
      if (state_reg.pmi_pend[k])
        state_next.div_pmi_vec = 4'(k);
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  warm_first_a: assert property (warm_take |=> divert_warm && !divert_pmi && !divert_ext)
    else $error("warm restart not ranked first");
  pmi_pin_a: assert property (pmi_pin && !state_reg.pmi_pin_q |=> state_reg.pmi_pend[0])
    else $error("management pin did not pend vector zero");
  reserved_bits_a: assert property (!state_reg.pend[1] && state_reg.pend[15:3] == 13'h0000)
    else $error("reserved vector became pending");
  top_general_a: assert property (p_found && p_vec >= VEC_GEN_LO
                                  |-> (state_reg.pend >> p_vec) == 256'd1)
    else $error("a higher pending vector was passed over");
  nmi_unmask_a: assert property (p_found && p_vec == VEC_NMI && !i_found |-> unmasked)
    else $error("non-maskable vector was masked");
  mmi_mask_a: assert property (state_reg.mask_all_maskable_bit && p_vec != VEC_NMI
                              |-> !unmasked)
    else $error("mask-all did not mask");
  class_mask_a: assert property (p_found && p_vec >= VEC_GEN_LO
                                && p_vec[7:4] <= state_reg.mask_class_field |-> !unmasked)
    else $error("class at or below mask level was unmasked");
  spurious_read_a: assert property (acq_hit && !unmasked
                                    |=> state_reg.rdata == 32'h0000_000F
                                    && $stable(state_reg.insvc))
    else $error("spurious acquire returned wrong value or changed state");
  acquire_mark_a: assert property (acq_hit && unmasked && !msg.valid
                                   |=> state_reg.insvc[$past(p_vec)]
                                   && !state_reg.pend[$past(p_vec)])
    else $error("acquire did not move vector to in-service");
  done_clear_a: assert property (done_hit && i_found |=> !state_reg.insvc[$past(i_vec)])
    else $error("service done did not retire top vector");
  done_idle_a: assert property (done_hit && !i_found && !msg.valid
                                |=> $stable(state_reg.pend) && $stable(state_reg.insvc))
    else $error("idle service done changed state");
  pmi_gate_a: assert property (divert_pmi |-> $past(state_reg.collect_enable_bit))
    else $error("management diverted while collection off");
  ext_gate_a: assert property (divert_ext |-> $past(ext_deliver))
    else $error("external diverted while delivery disabled");

  // Ranking and gating between the three request kinds and among external vectors
  pmi_second_a: assert property (pmi_take && !warm_take
                                 |=> divert_pmi && !divert_warm && !divert_ext)
    else $error("management not ranked above external");
  nmi_first_a: assert property (state_reg.pend[VEC_NMI] |-> p_vec == VEC_NMI)
    else $error("non-maskable vector not ranked first");
  cascade_next_a: assert property (state_reg.pend[VEC_LEGACY] && !state_reg.pend[VEC_NMI]
                                   |-> p_vec == VEC_LEGACY)
    else $error("legacy cascade vector not ranked second");
  insvc_mask_a: assert property (i_found && p_found
                                 && ipm_rank(p_vec) <= ipm_rank(i_vec) |-> !unmasked)
    else $error("vector at or below in-service level was unmasked");
  ext_divert_a: assert property (ext_deliver && unmasked && !warm_take && !pmi_take
                                 |=> divert_ext && ext_vector == $past(p_vec))
    else $error("unmasked external request was not diverted");
  warm_gate_a: assert property (divert_warm
                                |-> !$past(state_reg.machine_check_mask_bit))
    else $error("warm restart diverted while masked");

  // Arrival side: merging and separate vector spaces
  ext_pend_a: assert property (msg.valid && msg.kind == IPM_MSG_EXT
                               && !ipm_reserved(msg.vector)
                               |=> state_reg.pend[$past(msg.vector)])
    else $error("external request was not pended");
  pmi_apart_a: assert property (msg.valid && msg.kind == IPM_MSG_PMI && !acq_hit
                                |=> $stable(state_reg.pend))
    else $error("management request touched external pending bits");

endmodule // ipm_interrupt_priority

// file: verification/ipm_msg_source.sv
// Purpose: Far-side model of the interrupt message senders
// Assumes: One message per cycle, launched just after a rising edge
// Notes:   Idle message carries the inverted vector, so stale data never looks valid
`timescale 1ns/1ps
module ipm_msg_source
  import ipm_pkg::*;
(
  input  wire logic mclk,
  output ipm_msg_s  msg
);
  initial msg = '0;

  // Gap stretches the spacing to act as a slow sender
  task automatic send(input ipm_msg_kind_e kind, input logic [7:0] vec, input int gap);
    msg <= '{1'b1, kind, vec};
    @(posedge mclk);
    msg <= '{1'b0, kind, ~vec};
    repeat (gap + 1) @(posedge mclk);
  endtask
endmodule // ipm_msg_source

// file: verification/test_interrupt_priority_masking.sv
// Purpose: Self-checking bench for the interrupt priority block
// Assumes: Bench drives on rising edges, samples outputs at falling edges
// Notes:   Reference model keeps pending and in-service sets as bit arrays
`timescale 1ns/1ps
module test_interrupt_priority_masking;
  import ipm_pkg::*;
  logic        mclk, hreadyout, hresp, divert_warm, divert_pmi, divert_pmi_fw, divert_ext;
  logic        arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        warm_restart_pin = 1'b0, pmi_pin = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd, ctrl = '0, task_priority_reg = '0;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [3:0]  divert_pmi_vector;
  logic [7:0]  ext_vector;
  ipm_msg_s    msg;
  int          err_count = 0, samples_checked = 0, e, k;
  bit [255:0]  pend, isv;
  bit [15:0]   platform_mgmt_request;
  bit          warm;

  ipm_interrupt_priority i_ipm_interrupt_priority (.mclk(mclk), .arst_n(arst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .msg(msg), .warm_restart_pin(warm_restart_pin), .pmi_pin(pmi_pin),
    .divert_warm(divert_warm), .divert_pmi(divert_pmi),
    .divert_pmi_vector(divert_pmi_vector), .divert_pmi_fw(divert_pmi_fw),
    .divert_ext(divert_ext), .ext_vector(ext_vector));
  ipm_msg_source i_ipm_msg_source (.mclk(mclk), .msg(msg));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Ready is sampled at the falling edge: inputs only move on rising edges
  task automatic wait_rdy(output logic [31:0] d);
    logic r;
    r = 1'b0;
    for (int n = 0; !r; n++)
    begin
      if (n > 50)
      begin
        err_count++;
        finish_test();
      end
      @(negedge mclk);
      r = (hreadyout === 1'b1);
      d = hrdata;
      @(posedge mclk);
    end
  endtask

  task automatic ahb(input bit w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    wait_rdy(d);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy(d);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, 32'(a), d, rd);
  endtask

  function automatic int rank(int x);
    return (x == 2) ? 257 : (x == 0) ? 256 : (x >= 16) ? x : 0;
  endfunction

  function automatic int top_isv();
    int t;
    t = -1;
    for (int i = 0; i < 256; i++)
      if (isv[i] && (t < 0 || rank(i) > rank(t)))
        t = i;
    return t;
  endfunction

  function automatic int m_acq();
    int  b, t;
    bit  ok;
    b = -1;
    for (int i = 0; i < 256; i++)
      if (pend[i] && (b < 0 || rank(i) > rank(b)))
        b = i;
    if (b < 0)
      return 15;
    t = top_isv();
    ok = (t < 0) || (rank(b) > rank(t));
    if (b != 2)
      ok &= !task_priority_reg[MASK_ALL_MASKABLE_BIT_BIT];
    if (b >= 16)
      ok &= (b[7:4] > task_priority_reg[7:4]);
    return ok ? b : 15;
  endfunction

  task automatic ext(input int x, input int gap);
    i_ipm_msg_source.send(IPM_MSG_EXT, 8'(x), gap);
    if (x == 0 || x == 2 || x >= 16)
      pend[x] = 1'b1;
  endtask

  task automatic acq;
    e = m_acq();
    ahb(1'b0, 32'(OFF_ACQUIRE), '0, rd);
    check(rd, 32'(e));
    if (e != 15)
    begin
      pend[e] = 1'b0;
      isv[e] = 1'b1;
    end
  endtask

  task automatic done;
    ahb(1'b1, 32'(OFF_DONE), $urandom, rd);
    k = top_isv();
    if (k >= 0)
      isv[k] = 1'b0;
  endtask

  task automatic pulse(input bit w);
    if (w)
      warm_restart_pin <= 1'b1;
    else
      pmi_pin <= 1'b1;
    @(posedge mclk);
    warm_restart_pin <= 1'b0;
    pmi_pin <= 1'b0;
  endtask

  // Diverts lag the state by one edge, so two edges pass before sampling
  task automatic chk_out;
    bit dw, dp, dx;
    int pv;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    pv = 0;
    for (int i = 15; i >= 0; i--)
      if (platform_mgmt_request[i])
        pv = i;
    dw = warm && !ctrl[CTRL_MC_BIT];
    dp = (platform_mgmt_request != 0) && ctrl[CTRL_COLLECT_BIT] && !dw;
    dx = ctrl[CTRL_EXT_EN_BIT] && (!ctrl[CTRL_LEGACY_BIT] || !ctrl[CTRL_LCTRL_BIT]
         || ctrl[CTRL_LFLAGS_BIT]) && (m_acq() != 15) && !dw && !dp;
    check(32'(ext_vector), 32'(m_acq()));
    check(32'({hresp, divert_warm, divert_pmi, divert_ext}), 32'({1'b0, dw, dp, dx}));
    check(32'({divert_pmi_fw, divert_pmi_vector}), 32'({dp && pv >= 4, 4'(pv)}));
    @(posedge mclk);
  endtask

  task automatic chk_pend;
    for (int n = 0; n < 8; n++)
    begin
      ahb(1'b0, 32'h0000_0020 + 32'(4 * n), '0, rd);
      check(rd, pend[32 * n +: 32]);
      ahb(1'b0, 32'h0000_0040 + 32'(4 * n), '0, rd);
      check(rd, isv[32 * n +: 32]);
    end
  endtask

  task automatic drain;
    for (int j = 0; j < 40 && m_acq() != 15; j++)
    begin
      acq();
      chk_out();
      done();
      chk_out();
    end
  endtask

  initial
  begin
    repeat (100000) @(posedge mclk);
    err_count++;
    finish_test();
  end

  initial
  begin
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    void'($urandom(19));
    @(posedge mclk);
    chk_out();
    // Unmapped read right after a non-zero read, so stale data would show
    for (int i = 0; i < 5; i++)
    begin
      ahb(1'b0, (i == 3) ? 32'h0000_0100 : 32'(i * 4 + ((i > 1) ? 8 : 0)), '0, rd);
      check(rd, (i == 2) ? 32'h0000_0F00 : 32'h0000_0000);
    end
    ctrl = 32'h0000_0003;
    wr(OFF_CTRL, ctrl);
    // Random batches unmasked, then under a class mask, then under mask-all
    for (int p = 0; p < 3; p++)
    begin
      task_priority_reg = (p == 1) ? {24'h00_0000, 4'($urandom_range(1, 15)), 4'h0} :
            (p == 2) ? 32'h0001_0000 : 32'h0000_0000;
      wr(OFF_TPR, task_priority_reg);
      for (int j = 0; j < 12; j++)
        ext($urandom_range(0, 255), $urandom_range(0, 2));
      ext(0, 0);
      ext(2, 0);
      ext(1, 0);
      ext(9, 0);
      ext(8'h50, 0);
      ext(8'h50, 1);
      chk_out();
      chk_pend();
      drain();
      chk_pend();
    end
    task_priority_reg = 32'h0000_0000;
    wr(OFF_TPR, task_priority_reg);
    drain();
    // Nesting: 80 pre-empts 45, 70 waits behind 80, 40 behind 45
    ext(45, 0);
    acq();
    ext(80, 1);
    chk_out();
    acq();
    ext(70, 0);
    ext(40, 0);
    chk_out();
    done();
    chk_out();
    acq();
    repeat (3) done();
    chk_out();
    chk_pend();
    drain();
    // Delivery enable over every control combination
    ext(8'h90, 0);
    for (int c = 0; c < 64; c++)
    begin
      ctrl = 32'(c);
      wr(OFF_CTRL, ctrl);
      chk_out();
      ahb(1'b0, 32'(OFF_CTRL), '0, rd);
      check(rd, ctrl);
    end
    ctrl = 32'h0000_0003;
    wr(OFF_CTRL, ctrl);
    pulse(1'b0);
    platform_mgmt_request[0] = 1'b1;
    chk_out();
    i_ipm_msg_source.send(IPM_MSG_PMI, 8'h05, 0);
    i_ipm_msg_source.send(IPM_MSG_PMI, 8'h14, 2);
    platform_mgmt_request[5] = 1'b1;
    wr(OFF_FW_CLEAR, 32'h0001_0000);
    platform_mgmt_request[0] = 1'b0;
    chk_out();
    pulse(1'b1);
    warm = 1'b1;
    chk_out();
    ctrl = 32'h0000_0007;
    wr(OFF_CTRL, ctrl);
    chk_out();
    ctrl = 32'h0000_0001;
    wr(OFF_CTRL, ctrl);
    chk_out();
    wr(OFF_FW_CLEAR, 32'hFFFF_0001);
    warm = 1'b0;
    platform_mgmt_request = '0;
    chk_out();
    drain();
    finish_test();
  end
endmodule // test_interrupt_priority_masking
